// ### hw/mmd_pkg.sv
/*
 * Shared constants and types of the memory map decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mmd_pkg;

  // ****************************************************************
  // Program flash geometry
  // ****************************************************************
  localparam int          PROG_ADDR_W      = 16;
  localparam int          SECTOR_BYTES     = 128;
  localparam int          BYTE_SEL_W       = 7;
  localparam int          BLK0_SECTORS     = 512;
  localparam int          BLK1_SECTORS     = 64;
  localparam int          SECTOR_W         = 9;
  localparam logic [15:0] OVERLAY_TOP      = 16'h1FFF;

  // ****************************************************************
  // Bank switch field values
  // ****************************************************************
  localparam logic [1:0]  BANK_OVERLAY     = 2'h0;
  localparam logic [1:0]  BANK_POR_PROG    = 2'h1;
  localparam logic [1:0]  BANK_SW_UNPROG   = 2'h2;
  localparam logic [1:0]  BANK_SW_PROG     = 2'h3;

  // ****************************************************************
  // Data memory geometry
  // ****************************************************************
  localparam int          ONCHIP_RAM_BYTES = 1024;
  localparam int          EXPANDED_ONCHIP_RAM_BYTES       = 768;
  localparam int          EXPANDED_ONCHIP_RAM_W           = 10;
  localparam logic [15:0] EXPANDED_ONCHIP_RAM_TOP         = 16'h02FF;
  localparam logic [15:0] RI_EXPANDED_ONCHIP_RAM_TOP      = 16'h00FF;
  localparam int          UPPER_BIT        = 7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MMD_RST_POR_EXT,
    MMD_RST_WDT_BOD,
    MMD_RST_SOFT
  } mmd_rst_cause_e;

  typedef enum logic [1:0] {
    MMD_ACC_DIRECT,
    MMD_ACC_INDIRECT,
    MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_PTR,
    MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_REG
  } mmd_acc_kind_e;

  typedef enum logic [2:0] {
    MMD_TGT_NONE,
    MMD_TGT_LOWER_RAM,
    MMD_TGT_UPPER_RAM,
    MMD_TGT_SFR,
    MMD_TGT_EXPANDED_ONCHIP_RAM,
    MMD_TGT_EXT_BUS
  } mmd_target_e;

endpackage

// ### hw/mmd_dec_if.sv
/*
 * Carrier between the top decoder and its data-side decode module.
 * Assumes both ends sit in the clk_sys domain.
 */
`timescale 1ns/1ps
interface mmd_dec_if;
  import mmd_pkg::*;

  // Request side
  logic          req;
  mmd_acc_kind_e kind;
  logic [15:0]   addr;
  logic          xram_sel;
  // Decoded answer
  mmd_target_e   tgt;
  logic          ext_hi_drive;
  logic [9:0]    expanded_onchip_ram_addr;

  modport top (output req, kind, addr, xram_sel, input tgt, ext_hi_drive, expanded_onchip_ram_addr);
  modport dec (input req, kind, addr, xram_sel, output tgt, ext_hi_drive, expanded_onchip_ram_addr);
endinterface

// ### hw/mmd_data_decode.sv
/*
 * Combinational data-space decode: picks lower RAM, upper RAM, SFR,
 * expanded RAM or the external bus for one access.
 * Assumes the caller registers the answer.
 */
`timescale 1ns/1ps
module mmd_data_decode
  import mmd_pkg::*;
(
  // Decode request and answer
  mmd_dec_if.dec d
);

  // ****************************************************************
  // Target selection
  // ****************************************************************
  always_comb begin
    d.tgt          = MMD_TGT_NONE;
    d.ext_hi_drive = 1'b0;
    d.expanded_onchip_ram_addr    = d.addr[EXPANDED_ONCHIP_RAM_W-1:0];
    if (d.req) begin
      unique case (d.kind)
        // Low half shared, high half split by mode
        MMD_ACC_DIRECT:   d.tgt = d.addr[UPPER_BIT] ? MMD_TGT_SFR : MMD_TGT_LOWER_RAM;
        MMD_ACC_INDIRECT: d.tgt = d.addr[UPPER_BIT] ? MMD_TGT_UPPER_RAM : MMD_TGT_LOWER_RAM;
        MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_PTR: begin
          if (!d.xram_sel) begin
            // Pointer reach stops at 0FFH
            d.tgt       = MMD_TGT_EXPANDED_ONCHIP_RAM;
            d.expanded_onchip_ram_addr = {2'h0, d.addr[7:0]};
          end else begin
            d.tgt = MMD_TGT_EXT_BUS;  // 8-bit paged cycle
          end
        end
        MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_REG: begin
          if (!d.xram_sel && d.addr <= EXPANDED_ONCHIP_RAM_TOP) begin
            d.tgt = MMD_TGT_EXPANDED_ONCHIP_RAM;
          end else begin
            d.tgt          = MMD_TGT_EXT_BUS;
            d.ext_hi_drive = 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// ### hw/mmd_memory_map_decoder.sv
/*
 * Memory map decoder: program flash bank overlay and sector split,
 * data space target selection and external bus address outputs.
 * Assumes the core issues at most one fetch, one programming access
 * and one data access per cycle, all synchronous to clk_sys.
 */
// Notes on behaviour
// - Primary flash: 512 sectors of 128 bytes
// - Secondary flash: 64 sectors of 128 bytes
// - Low seven bits byte, rest sector
// - Field 00 overlays secondary on low 8K
// - Otherwise secondary reached only by programming
// - Hidden primary low 8K stays programmable
// - Field loaded at reset from start-up bit
// - Software changes bit 0 only, start-up kept
// - 1024 bytes on chip, 64K external
// - 00H-7FH direct and indirect
// - Upper half: indirect RAM, direct SFR
// - Select low: 000H-2FFH goes to expanded RAM
// - Expanded RAM via pointers or data pointer
// - Expanded RAM leaves ports and strobes alone
// - Select low: above 2FFH runs external cycle
// - Select high: pointer moves, 8-bit external cycle
// - Data pointer moves drive 16-bit address
// - High port upper byte, low port lower
// - Select low: pointer moves only 0-0FFH
`timescale 1ns/1ps
module mmd_memory_map_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // Reset configuration
  input  mmd_rst_cause_e       rst_cause,
  input  wire logic            startup_bank_bit,
  // Run-time bank write
  input  wire logic            bank_wr,
  input  wire logic            bank_wr_bit0,
  output logic [1:0]           bank_switch_config,
  // Instruction fetch
  input  wire logic            fetch_req,
  input  wire logic [15:0]     fetch_addr,
  // In-application programming access
  input  wire logic            iap_req,
  input  wire logic [15:0]     iap_addr,
  input  wire logic            iap_blk1,
  // Flash select answer
  output logic                 prog_valid,
  output logic                 prog_err,
  output logic                 prog_blk1,
  output logic [SECTOR_W-1:0]  prog_sector,
  output logic [BYTE_SEL_W-1:0] prog_byte,
  // Data access
  input  wire logic            data_req,
  input  mmd_acc_kind_e        data_kind,
  input  wire logic [15:0]     data_addr,
  input  wire logic            external_ram_select,
  // Data target answer
  output logic                 data_valid,
  output mmd_target_e          data_target,
  output logic [7:0]           ram_addr,
  output logic [EXPANDED_ONCHIP_RAM_W-1:0]    expanded_onchip_ram_addr,
  // External bus cycle
  output logic                 ext_cycle,
  output logic [7:0]           low_addr_data_port,
  output logic [7:0]           high_addr_port,
  output logic                 high_addr_drive
);

  // ****************************************************************
  // Bank switch field
  // ****************************************************************
  logic [1:0] bank_q;
  logic [1:0] bank_d;

  // Next bank value from reset cause or software write
  always_comb begin
    bank_d = bank_q;
    if (rst) begin
      unique case (rst_cause)
        MMD_RST_POR_EXT: bank_d = startup_bank_bit ? BANK_OVERLAY : BANK_POR_PROG;
        MMD_RST_WDT_BOD: bank_d = {bank_q[1], ~startup_bank_bit};
        MMD_RST_SOFT:    bank_d = startup_bank_bit ? BANK_SW_UNPROG : BANK_SW_PROG;
        default:         bank_d = startup_bank_bit ? BANK_OVERLAY : BANK_POR_PROG;
      endcase
    end else if (bank_wr) begin
      bank_d = {bank_q[1], bank_wr_bit0};
    end
  end

  // Bank register
  always_ff @(posedge clk_sys) begin
    bank_q <= bank_d;
  end

  assign bank_switch_config = bank_q;

  // ****************************************************************
  // Program side decode
  // ****************************************************************
  logic                  pv_q, pv_d;
  logic                  perr_q, perr_d;
  logic                  pb1_q, pb1_d;
  logic [SECTOR_W-1:0]   psec_q, psec_d;
  logic [BYTE_SEL_W-1:0] pbyte_q, pbyte_d;

  // Which block and sector serve the access
  always_comb begin
    pv_d    = 1'b0;
    perr_d  = 1'b0;
    pb1_d   = pb1_q;
    psec_d  = psec_q;
    pbyte_d = pbyte_q;
    if (fetch_req) begin
      // Fetch wins over a programming access in the same cycle
      pv_d    = 1'b1;
      pb1_d   = (bank_q == BANK_OVERLAY) && (fetch_addr <= OVERLAY_TOP);
      psec_d  = fetch_addr[PROG_ADDR_W-1:BYTE_SEL_W];
      pbyte_d = fetch_addr[BYTE_SEL_W-1:0];
    end else if (iap_req) begin
      // Either block's low 8K by explicit select
      if (iap_blk1 && iap_addr > OVERLAY_TOP) begin
        perr_d = 1'b1;  // Beyond the 64 secondary sectors
      end else begin
        pv_d    = 1'b1;
        pb1_d   = iap_blk1;
        psec_d  = iap_addr[PROG_ADDR_W-1:BYTE_SEL_W];
        pbyte_d = iap_addr[BYTE_SEL_W-1:0];
      end
    end
  end

  // Program answer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pv_q    <= 1'b0;
      perr_q  <= 1'b0;
      pb1_q   <= 1'b0;
      psec_q  <= '0;
      pbyte_q <= '0;
    end else begin
      pv_q    <= pv_d;
      perr_q  <= perr_d;
      pb1_q   <= pb1_d;
      psec_q  <= psec_d;
      pbyte_q <= pbyte_d;
    end
  end

  assign prog_valid  = pv_q;
  assign prog_err    = perr_q;
  assign prog_blk1   = pb1_q;
  assign prog_sector = psec_q;
  assign prog_byte   = pbyte_q;

  // ****************************************************************
  // Data side decode
  // ****************************************************************
  mmd_dec_if dec_if ();

  assign dec_if.req      = data_req;
  assign dec_if.kind     = data_kind;
  assign dec_if.addr     = data_addr;
  assign dec_if.xram_sel = external_ram_select;

  mmd_data_decode u_dec (
    .d (dec_if.dec)
  );

  logic              dv_q, dv_d;
  mmd_target_e       dt_q, dt_d;
  logic [7:0]        ra_q, ra_d;
  logic [EXPANDED_ONCHIP_RAM_W-1:0] ea_q, ea_d;
  logic              xc_q, xc_d;
  logic [7:0]        lo_q, lo_d;
  logic [7:0]        hi_q, hi_d;
  logic              hd_q, hd_d;

  // Data answer; port outputs move only for external cycles
  always_comb begin
    dv_d = data_req;
    dt_d = dec_if.tgt;
    ra_d = ra_q;
    ea_d = ea_q;
    xc_d = 1'b0;
    lo_d = lo_q;
    hi_d = hi_q;
    hd_d = hd_q;
    unique case (dec_if.tgt)
      MMD_TGT_LOWER_RAM,
      MMD_TGT_UPPER_RAM,
      MMD_TGT_SFR:  ra_d = data_addr[7:0];
      MMD_TGT_EXPANDED_ONCHIP_RAM: ea_d = dec_if.expanded_onchip_ram_addr;  // Ports held
      MMD_TGT_EXT_BUS: begin
        xc_d = 1'b1;
        lo_d = data_addr[7:0];
        hd_d = dec_if.ext_hi_drive;
        if (dec_if.ext_hi_drive) begin
          hi_d = data_addr[15:8];  // Full 64K reach
        end
      end
      default: dv_d = data_req;
    endcase
  end

  // Data answer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dv_q <= 1'b0;
      dt_q <= MMD_TGT_NONE;
      ra_q <= '0;
      ea_q <= '0;
      xc_q <= 1'b0;
      lo_q <= '0;
      hi_q <= '0;
      hd_q <= 1'b0;
    end else begin
      dv_q <= dv_d;
      dt_q <= dt_d;
      ra_q <= ra_d;
      ea_q <= ea_d;
      xc_q <= xc_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      hd_q <= hd_d;
    end
  end

  assign data_valid         = dv_q;
  assign data_target        = dt_q;
  assign ram_addr           = ra_q;
  assign expanded_onchip_ram_addr          = ea_q;
  assign ext_cycle          = xc_q;
  assign low_addr_data_port = lo_q;
  assign high_addr_port     = hi_q;
  assign high_addr_drive    = hd_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_overlay_fetch;
    @(posedge clk_sys) disable iff (rst)
      fetch_req && bank_q == BANK_OVERLAY && fetch_addr <= OVERLAY_TOP |=> prog_valid && prog_blk1;
  endproperty
  a_overlay_fetch: assert property (p_overlay_fetch) else $error("overlay fetch not from secondary");

  property p_hidden_blk1;
    @(posedge clk_sys) disable iff (rst)
      fetch_req && (bank_q != BANK_OVERLAY || fetch_addr > OVERLAY_TOP) |=> !prog_blk1;
  endproperty
  a_hidden_blk1: assert property (p_hidden_blk1) else $error("secondary visible to fetch");

  property p_iap_low_blk0;
    @(posedge clk_sys) disable iff (rst)
      !fetch_req && iap_req && !iap_blk1 |=> prog_valid && !prog_blk1 && !prog_err;
  endproperty
  a_iap_low_blk0: assert property (p_iap_low_blk0) else $error("primary low 8K not programmable");

  property p_sector_split;
    @(posedge clk_sys) disable iff (rst)
      fetch_req |=> prog_sector == $past(fetch_addr[15:7]) && prog_byte == $past(fetch_addr[6:0]);
  endproperty
  a_sector_split: assert property (p_sector_split) else $error("sector or byte split wrong");

  property p_por_load;
    @(posedge clk_sys)
      rst && rst_cause == MMD_RST_POR_EXT |=> bank_switch_config == {1'b0, !$past(startup_bank_bit)};
  endproperty
  a_por_load: assert property (p_por_load) else $error("power-on bank value wrong");

  property p_sw_bit0;
    @(posedge clk_sys) disable iff (rst)
      bank_wr |=> bank_switch_config[0] == $past(bank_wr_bit0) && $stable(bank_switch_config[1]);
  endproperty
  a_sw_bit0: assert property (p_sw_bit0) else $error("bank bit write wrong");

  property p_direct_sfr;
    @(posedge clk_sys) disable iff (rst)
      data_req && data_kind == MMD_ACC_DIRECT && data_addr[7] |=> data_target == MMD_TGT_SFR;
  endproperty
  a_direct_sfr: assert property (p_direct_sfr) else $error("direct upper access missed SFR");

  property p_expanded_onchip_ram_quiet;
    @(posedge clk_sys) disable iff (rst)
      data_req && dec_if.tgt == MMD_TGT_EXPANDED_ONCHIP_RAM |=>
        !ext_cycle && $stable(low_addr_data_port) && $stable(high_addr_port) && $stable(high_addr_drive);
  endproperty
  a_expanded_onchip_ram_quiet: assert property (p_expanded_onchip_ram_quiet) else $error("expanded RAM disturbed ports");

  property p_ptr_expanded_onchip_ram_low;
    @(posedge clk_sys) disable iff (rst)
      data_req && data_kind == MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_PTR && !external_ram_select |=>
        data_target == MMD_TGT_EXPANDED_ONCHIP_RAM && expanded_onchip_ram_addr[9:8] == 2'h0 && !ext_cycle;
  endproperty
  a_ptr_expanded_onchip_ram_low: assert property (p_ptr_expanded_onchip_ram_low) else $error("pointer move left low expanded RAM");

  property p_data_pointer_reg_ext;
    @(posedge clk_sys) disable iff (rst)
      data_req && data_kind == MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_REG && data_addr > EXPANDED_ONCHIP_RAM_TOP |=>
        ext_cycle && high_addr_drive && {high_addr_port, low_addr_data_port} == $past(data_addr);
  endproperty
  a_data_pointer_reg_ext: assert property (p_data_pointer_reg_ext) else $error("data pointer cycle address wrong");

  c_overlay_fetch: cover property (@(posedge clk_sys) disable iff (rst) fetch_req && bank_q == BANK_OVERLAY);
  c_expanded_onchip_ram_access:   cover property (@(posedge clk_sys) disable iff (rst) data_valid && data_target == MMD_TGT_EXPANDED_ONCHIP_RAM);
  c_ext_cycle:     cover property (@(posedge clk_sys) disable iff (rst) ext_cycle && !high_addr_drive);
  c_bank_write:    cover property (@(posedge clk_sys) disable iff (rst) bank_wr ##1 fetch_req);

endmodule

// ### tb/mmd_core_model.sv
/*
 * Core-side model: issues resets, bank writes, fetches, programming
 * and data accesses to the decoder, one request per task call except fetch_iap and bank.
 * Assumes the decoder samples on the rising edge of clk_sys.
 */
`timescale 1ns/1ps
module mmd_core_model
  import mmd_pkg::*;
(
  // Clock
  input  wire logic      clk_sys,
  // Reset configuration
  output logic           rst,
  output mmd_rst_cause_e rst_cause,
  output logic           startup_bank_bit,
  // Bank write
  output logic           bank_wr,
  output logic           bank_wr_bit0,
  // Program side
  output logic           fetch_req,
  output logic [15:0]    fetch_addr,
  output logic           iap_req,
  output logic [15:0]    iap_addr,
  output logic           iap_blk1,
  // Data side
  output logic           data_req,
  output mmd_acc_kind_e  data_kind,
  output logic [15:0]    data_addr,
  output logic           external_ram_select
);
  // Levels at time zero, reset held
  initial begin
    rst = 1'b1;
    rst_cause = MMD_RST_POR_EXT;
    startup_bank_bit = 1'b1;
    bank_wr = 1'b0;
    bank_wr_bit0 = 1'b0;
    fetch_req = 1'b0;
    fetch_addr = 16'h0000;
    iap_req = 1'b0;
    iap_addr = 16'h0000;
    iap_blk1 = 1'b0;
    data_req = 1'b0;
    data_kind = MMD_ACC_DIRECT;
    data_addr = 16'h0000;
    external_ram_select = 1'b0;
  end

  // Step to just after the next rising edge
  task automatic edge1();
    @(posedge clk_sys);
    #1;
  endtask

  // Reset of given cause for n edges
  task automatic reset_dev(input mmd_rst_cause_e c, input logic b, input int n);
    edge1();
    rst = 1'b1;
    rst_cause = c;
    startup_bank_bit = b;
    repeat (n) @(posedge clk_sys);
    #1;
    rst = 1'b0;
  endtask

  // Released lines show the inverse of their last value
  task automatic fetch(input logic [15:0] a);
    edge1();
    fetch_req = 1'b1;
    fetch_addr = a;
    edge1();
    fetch_req = 1'b0;
    fetch_addr = ~a;
  endtask

  // Programming access
  task automatic in_app_programming(input logic [15:0] a, input logic b);
    edge1();
    iap_req = 1'b1;
    iap_addr = a;
    iap_blk1 = b;
    edge1();
    iap_req = 1'b0;
    iap_addr = ~a;
    iap_blk1 = ~b;
  endtask

  // Fetch and programming access raised in one cycle
  task automatic fetch_iap(input logic [15:0] a, input logic [15:0] ia);
    edge1();
    fetch_req = 1'b1;
    fetch_addr = a;
    iap_req = 1'b1;
    iap_addr = ia;
    iap_blk1 = 1'b1;
    edge1();
    fetch_req = 1'b0;
    fetch_addr = ~a;
    iap_req = 1'b0;
    iap_addr = ~ia;
    iap_blk1 = 1'b0;
  endtask

  // Switch instruction fetched from above the low 8K
  task automatic bank(input logic b);
    edge1();
    bank_wr = 1'b1;
    bank_wr_bit0 = b;
    fetch_req = 1'b1;
    fetch_addr = 16'h4000;
    edge1();
    bank_wr = 1'b0;
    bank_wr_bit0 = ~b;
    fetch_req = 1'b0;
    fetch_addr = 16'hBFFF;
  endtask

  // Data access
  task automatic data(input mmd_acc_kind_e k, input logic [15:0] a, input logic s);
    edge1();
    data_req = 1'b1;
    data_kind = k;
    data_addr = a;
    external_ram_select = s;
    edge1();
    data_req = 1'b0;
    data_addr = ~a;
  endtask
endmodule

// ### tb/memory_map_decoder_tb.sv
/*
 * Self-checking bench of the memory map decoder: resets, bank
 * writes, fetch and programming decode, data target decode.
 * Assumes the core model in mmd_core_model drives all requests.
 */
`timescale 1ns/1ps
module memory_map_decoder_tb
  import mmd_pkg::*;
;
  logic clk_sys, rst, startup_bank_bit, bank_wr, bank_wr_bit0;
  logic fetch_req, iap_req, iap_blk1, data_req, external_ram_select;
  logic prog_valid, prog_err, prog_blk1, data_valid, ext_cycle, high_addr_drive;
  logic [15:0] fetch_addr, iap_addr, data_addr;
  logic [1:0] bank_switch_config;
  logic [SECTOR_W-1:0] prog_sector;
  logic [BYTE_SEL_W-1:0] prog_byte;
  logic [7:0] ram_addr, low_addr_data_port, high_addr_port;
  logic [EXPANDED_ONCHIP_RAM_W-1:0] expanded_onchip_ram_addr;
  mmd_rst_cause_e rst_cause;
  mmd_acc_kind_e data_kind;
  mmd_target_e data_target;
  int bad_count, comparisons;
  // Expected state
  logic [1:0] e_bank;
  logic e_blk, e_drv;
  logic [8:0] e_sec;
  logic [6:0] e_byt;
  logic [7:0] e_ram, e_lo, e_hi;
  logic [9:0] e_er;
  logic [15:0] corner [6] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h007F, 16'h0080, 16'hFFFF};
  logic [15:0] dcorn [4] = '{16'h0000, 16'h02FF, 16'h0300, 16'hFFFF};

  // Core model and decoder
  mmd_core_model core (.clk_sys, .rst, .rst_cause, .startup_bank_bit, .bank_wr, .bank_wr_bit0,
    .fetch_req, .fetch_addr, .iap_req, .iap_addr, .iap_blk1, .data_req, .data_kind, .data_addr,
    .external_ram_select);
  mmd_memory_map_decoder uut (.clk_sys, .rst, .rst_cause, .startup_bank_bit, .bank_wr,
    .bank_wr_bit0, .bank_switch_config, .fetch_req, .fetch_addr, .iap_req, .iap_addr, .iap_blk1,
    .prog_valid, .prog_err, .prog_blk1, .prog_sector, .prog_byte, .data_req, .data_kind,
    .data_addr, .external_ram_select, .data_valid, .data_target, .ram_addr, .expanded_onchip_ram_addr,
    .ext_cycle, .low_addr_data_port, .high_addr_port, .high_addr_drive);

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bank field after a reset
  function automatic logic [1:0] f_bank(mmd_rst_cause_e c, logic b, logic [1:0] old);
    case (c)
      MMD_RST_POR_EXT: return b ? 2'h0 : 2'h1;
      MMD_RST_WDT_BOD: return {old[1], ~b};
      default: return b ? 2'h2 : 2'h3;
    endcase
  endfunction

  // Flash select fields
  task automatic chk_prog();
    chk("prog_blk1", 16'(prog_blk1), 16'(e_blk));
    chk("prog_sector", 16'(prog_sector), 16'(e_sec));
    chk("prog_byte", 16'(prog_byte), 16'(e_byt));
  endtask

  task automatic t_rst(input mmd_rst_cause_e c, input logic b, input int n);
    core.reset_dev(c, b, n);
    e_bank = f_bank(c, b, e_bank);
    e_blk = 1'b0;
    e_sec = 9'h000;
    e_byt = 7'h00;
    chk("bank_switch_config", 16'(bank_switch_config), 16'(e_bank));
    chk_prog();
  endtask

  task automatic t_bank(input logic b);
    core.bank(b);
    e_bank = {e_bank[1], b};
    e_blk = 1'b0;
    e_sec = 9'h080;
    e_byt = 7'h00;
    chk("bank_switch_config", 16'(bank_switch_config), 16'(e_bank));
    chk_prog();
  endtask

  task automatic t_fetch(input logic [15:0] a);
    core.fetch(a);
    e_blk = (e_bank == 2'h0) && (a <= 16'h1FFF);
    e_sec = a[15:7];
    e_byt = a[6:0];
    chk("prog_valid", 16'(prog_valid), 16'h0001);
    chk_prog();
  endtask

  // Fetch wins; the refused secondary access must not flag
  task automatic t_both(input logic [15:0] a);
    core.fetch_iap(a, 16'h3F80);
    e_blk = (e_bank == 2'h0) && (a <= 16'h1FFF);
    e_sec = a[15:7];
    e_byt = a[6:0];
    chk("prog_err", 16'(prog_err), 16'h0000);
    chk("prog_valid", 16'(prog_valid), 16'h0001);
    chk_prog();
  endtask

  // Secondary block above 1FFFH is refused, fields hold
  task automatic t_iap(input logic [15:0] a, input logic b);
    logic err;
    core.in_app_programming(a, b);
    err = b && (a > 16'h1FFF);
    chk("prog_err", 16'(prog_err), 16'(err));
    chk("prog_valid", 16'(prog_valid), 16'(!err));
    if (!err) begin
      e_blk = b;
      e_sec = a[15:7];
      e_byt = a[6:0];
    end
    chk_prog();
  endtask

  task automatic t_data(input mmd_acc_kind_e k, input logic [15:0] a, input logic s);
    mmd_target_e t;
    core.data(k, a, s);
    case (k)
      MMD_ACC_DIRECT: t = a[7] ? MMD_TGT_SFR : MMD_TGT_LOWER_RAM;
      MMD_ACC_INDIRECT: t = a[7] ? MMD_TGT_UPPER_RAM : MMD_TGT_LOWER_RAM;
      MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_PTR: t = s ? MMD_TGT_EXT_BUS : MMD_TGT_EXPANDED_ONCHIP_RAM;
      default: t = (!s && a <= 16'h02FF) ? MMD_TGT_EXPANDED_ONCHIP_RAM : MMD_TGT_EXT_BUS;
    endcase
    if (t == MMD_TGT_EXPANDED_ONCHIP_RAM) begin
      e_er = (k == MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_PTR) ? {2'h0, a[7:0]} : a[9:0];
    end else if (t == MMD_TGT_EXT_BUS) begin
      e_lo = a[7:0];
      e_drv = (k == MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_REG);
      if (e_drv) e_hi = a[15:8];
    end else begin
      e_ram = a[7:0];
    end
    chk("data_valid", 16'(data_valid), 16'h0001);
    chk("data_target", 16'(data_target), 16'(t));
    chk("ext_cycle", 16'(ext_cycle), 16'(t == MMD_TGT_EXT_BUS));
    chk("ram_addr", 16'(ram_addr), 16'(e_ram));
    chk("expanded_onchip_ram_addr", 16'(expanded_onchip_ram_addr), 16'(e_er));
    chk("low_addr_data_port", 16'(low_addr_data_port), 16'(e_lo));
    chk("high_addr_port", 16'(high_addr_port), 16'(e_hi));
    chk("high_addr_drive", 16'(high_addr_drive), 16'(e_drv));
    @(posedge clk_sys);
    #1;
    chk("data_valid", 16'(data_valid), 16'h0000);
    chk("data_target", 16'(data_target), 16'(MMD_TGT_NONE));
    chk("ext_cycle", 16'(ext_cycle), 16'h0000);
  endtask

  // Main sequence
  initial begin
    logic [15:0] a;
    mmd_acc_kind_e k;
    bad_count = 0;
    comparisons = 0;
    e_bank = 2'h0;
    void'($urandom(32'hcd1f1c8a));
    t_rst(MMD_RST_POR_EXT, 1'b1, 19);
    for (int i = 0; i < 14; i++) begin
      if (i > 0) t_rst(mmd_rst_cause_e'($urandom_range(2)), 1'($urandom_range(1)), 2);
      if (i % 3 == 1) t_bank(1'($urandom_range(1)));
      foreach (corner[j]) t_fetch(corner[j]);
      t_fetch(16'($urandom));
      t_both(16'($urandom));
      t_iap(16'($urandom_range(16'h3FFF)), 1'($urandom_range(1)));
      t_iap(16'h1FFF, 1'b1);
      t_iap(16'h2000, 1'b1);
      t_iap(16'h0000, 1'b0);
    end
    $display("test reset_bank_fetch done");
    e_ram = 8'h00;
    e_er = 10'h000;
    e_lo = 8'h00;
    e_hi = 8'h00;
    e_drv = 1'b0;
    for (int i = 0; i < 240; i++) begin
      k = mmd_acc_kind_e'($urandom_range(3));
      a = {8'h00, 8'($urandom)};
      if (k == MMD_ACC_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_REG) begin
        a = (i % 4 == 0) ? dcorn[(i / 4) % 4] : 16'($urandom);
        if (i % 4 == 1) a = a & 16'h03FF;
      end
      t_data(k, a, 1'($urandom_range(1)));
    end
    $display("test data_decode done");
    summarize();
  end
endmodule
